//--- rtl/rtcs_pkg.sv
/*
  Package of the real-time counter control/status block: config-port
  addresses, control field layout, prescaler figures.
  Assumes an 8-bit configuration port clocked by the system clock.
*/
`default_nettype none
package rtcs_pkg;
  // ==========================================================
  // Config-port addresses
  localparam logic [7:0] ADDR_COUNTER_BASE = 8'h40;
  localparam logic [7:0] ADDR_MATCH_BASE = 8'h48;
  localparam logic [7:0] ADDR_CTRL_STAT = 8'h58;
  localparam logic [4:0] BYTE_SPAN_HI = 5'h08;
  localparam logic [2:0] BYTE_COUNT = 3'h5;
  // ==========================================================
  // Control/status reset value
  localparam logic [7:0] CTRL_RESET = 8'h00;
  // Advised crystal mode for a 32 kHz crystal
  localparam logic [1:0] MODE_32K = 2'h1;
  // ==========================================================
  // Prescaler: divide by 128, first count on the 64th edge
  localparam int unsigned PRESCALE_DIV = 128;
  localparam logic [6:0] PRESCALE_FIRST = 7'h3f;
  localparam int unsigned RELEASE_EDGES = 2;
  localparam int unsigned COUNT_W = 40;

  typedef struct packed {
    logic rtc_reset;
    logic cntr_en;
    logic regulator_wake_on_match;
    logic [1:0] oscillator_mode_field;
    logic clear_on_match;
    logic count_run;
    logic osc_own;
  } rtcs_ctrl_t;
endpackage
`default_nettype wire

//--- rtl/rtcs_control.sv
/*
  Control/status logic of the real-time counter: control register,
  internal reset release, /128 prescaler, 40-bit counter and match.
  Assumes crystal clock and supply-good arrive asynchronously and are
  synchronised here; config-port writes are single-cycle strobes.
  The crystal must run well below the system clock so that every
  edge is seen; a faster crystal would lose counts silently.
*/
`timescale 1ns/1ps
`default_nettype none
module rtcs_control
(
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_crystal_clock_in,
  input wire logic i_supply_good,
  input wire logic [7:0] i_cfg_addr,
  input wire logic [7:0] i_cfg_wdata,
  input wire logic i_cfg_wr,
  output logic [7:0] o_cfg_rdata,
  output logic o_regulator_match_out,
  output logic o_match_raw,
  output logic [1:0] o_osc_mode_out,
  output logic o_osc_select_out
);
  localparam int CW = rtcs_pkg::COUNT_W;

  // ==========================================================
  // Byte access helpers
  function automatic logic [CW-1:0] byte_put(input logic [CW-1:0] word,
                                             input logic [2:0] idx,
                                             input logic [7:0] data);
    logic [CW-1:0] r;
    r = word;
    r[{idx, 3'h0} +: 8] = data;
    return r;
  endfunction

  function automatic logic [7:0] byte_get(input logic [CW-1:0] word,
                                          input logic [2:0] idx);
    return word[{idx, 3'h0} +: 8];
  endfunction

  function automatic logic in_bank(input logic [7:0] addr,
                                   input logic [7:0] base);
    // Low three bits pick the byte within a five-byte bank
    return (addr & ~8'h07) == base;
  endfunction

  // ==========================================================
  // Synchronisers for pins
  // Two sync flops each, plus an edge-history flop on the crystal: both pins are asynchronous to the port clock
  logic [1:0] sup_sync_q;
  logic [2:0] xtal_sync_q;
  wire sup_s = sup_sync_q[1];
  // Idle-low history after reset, so a crystal already high gives one edge after it
  wire xtal_edge = xtal_sync_q[1] & ~xtal_sync_q[2];

  always_ff @(posedge i_clock)
  begin
    if (i_rst)
    begin
      sup_sync_q <= 2'h0;
      xtal_sync_q <= 3'h0;
    end
    else
    begin
      sup_sync_q <= {sup_sync_q[0], i_supply_good};
      xtal_sync_q <= {xtal_sync_q[1:0], i_crystal_clock_in};
    end
  end

  // ==========================================================
  // Config-port decode
  rtcs_pkg::rtcs_ctrl_t ctrl_q;
  logic [CW-1:0] cnt_q;
  logic [CW-1:0] match_q;
  wire [2:0] byte_idx = i_cfg_addr[2:0];
  wire idx_ok = byte_idx < rtcs_pkg::BYTE_COUNT;
  wire in_cnt = in_bank(i_cfg_addr, rtcs_pkg::ADDR_COUNTER_BASE);
  wire in_match = in_bank(i_cfg_addr, rtcs_pkg::ADDR_MATCH_BASE);
  wire wr_ctrl = i_cfg_wr && i_cfg_addr == rtcs_pkg::ADDR_CTRL_STAT;
  wire wr_cnt = i_cfg_wr && in_cnt && idx_ok;
  wire wr_match = i_cfg_wr && in_match && idx_ok;
  wire rd_ctrl = i_cfg_addr == rtcs_pkg::ADDR_CTRL_STAT;
  wire rd_cnt = in_cnt && idx_ok;
  wire rd_match = in_match && idx_ok;
  // Reads are pure muxes, nothing is touched
  // Unmapped and test addresses read as zero
  wire [7:0] rd_mux = rd_ctrl ? ctrl_q :
                      rd_cnt ? byte_get(cnt_q, byte_idx) :
                      rd_match ? byte_get(match_q, byte_idx) : 8'h00;

  // ==========================================================
  // Control register
  always_ff @(posedge i_clock)
  begin
    if (i_rst || !sup_s)
      ctrl_q <= rtcs_pkg::CTRL_RESET;
    else if (wr_ctrl)
      ctrl_q <= i_cfg_wdata;
  end

  // ==========================================================
  // Internal reset and its two-edge release
  // Released on the port clock only, never on the crystal
  logic [1:0] rel_q;
  wire run_ok = sup_s && !ctrl_q.rtc_reset;
  // Assert acts in the same cycle; only release waits for the edges
  wire int_rst = !run_ok || !rel_q[1];

  always_ff @(posedge i_clock)
  begin
    if (i_rst || !run_ok)
      rel_q <= 2'h0;
    else
      rel_q <= {rel_q[0], 1'b1};
  end

  // ==========================================================
  // Prescaler and counter
  // Tick at the halfway point: first count after 64 edges, then every 128
  logic [6:0] psc_q;
  // Either control bit stops the prescaler, so restarts begin at zero
  wire psc_hold = int_rst || !ctrl_q.cntr_en || !ctrl_q.count_run;
  wire tick = !psc_hold && xtal_edge && psc_q == rtcs_pkg::PRESCALE_FIRST;
  wire eq = cnt_q == match_q;
  // Clear skipped at zero, else the counter could never leave it
  wire clr_hit = ctrl_q.clear_on_match && eq && cnt_q != '0;

  always_ff @(posedge i_clock)
  begin
    if (i_rst || psc_hold)
      psc_q <= 7'h0;
    else if (xtal_edge)
      psc_q <= psc_q + 7'h1;
  end

  always_ff @(posedge i_clock)
  begin
    if (i_rst || int_rst || !ctrl_q.count_run)
      cnt_q <= '0;
    else if (wr_cnt)
      cnt_q <= byte_put(cnt_q, byte_idx, i_cfg_wdata);
    else if (tick)
      cnt_q <= clr_hit ? '0 : cnt_q + 40'h1;
  end

  always_ff @(posedge i_clock)
  begin
    if (i_rst || int_rst)
      match_q <= '0;
    else if (wr_match)
      match_q <= byte_put(match_q, byte_idx, i_cfg_wdata);
  end

  // ==========================================================
  // Registered outputs
  // All outputs registered so the regulator sees no decode glitches
  always_ff @(posedge i_clock)
  begin
    if (i_rst)
    begin
      o_cfg_rdata <= 8'h00;
      o_regulator_match_out <= 1'b0;
      o_match_raw <= 1'b0;
      o_osc_mode_out <= 2'h0;
      o_osc_select_out <= 1'b0;
    end
    else
    begin
      o_cfg_rdata <= rd_mux;
      o_regulator_match_out <= eq && ctrl_q.regulator_wake_on_match;
      o_match_raw <= eq;
      o_osc_mode_out <= ctrl_q.oscillator_mode_field;
      o_osc_select_out <= ctrl_q.osc_own;
    end
  end

  // ==========================================================
  // Assertions
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);

  a_ctrl_supply_low: assert property (!sup_s |=> ctrl_q == 8'h00)
    else $error("control not cleared under low supply");
  a_reset_release: assert property ($fell(int_rst) |-> $past(run_ok) && $past(run_ok, 2))
    else $error("reset released too early");
  a_reset_assert: assert property (!run_ok |-> int_rst ##1 psc_q == 7'h0)
    else $error("reset not immediate");
  a_tick_spacing: assert property (tick |=> !tick [*8])
    else $error("ticks too close");
  a_tick_point: assert property (tick |-> $past(psc_q) == rtcs_pkg::PRESCALE_FIRST ||
                                          psc_q == rtcs_pkg::PRESCALE_FIRST)
    else $error("tick off prescaler point");
  a_hold_disabled: assert property (!ctrl_q.cntr_en && !wr_cnt && !int_rst && ctrl_q.count_run
                                    |=> $stable(cnt_q) && psc_q == 7'h0)
    else $error("counter moved while disabled");
  a_count_zero: assert property (!ctrl_q.count_run |=> cnt_q == '0)
    else $error("counter not held at zero");
  a_clear_match: assert property (tick && clr_hit && !wr_cnt && !int_rst |=> cnt_q == '0)
    else $error("counter not cleared on match");
  a_count_up: assert property (tick && !clr_hit && !wr_cnt && !int_rst
                               |=> cnt_q == $past(cnt_q) + 40'h1)
    else $error("counter did not advance");
  a_regulator_gate: assert property (o_regulator_match_out == $past(eq && ctrl_q.regulator_wake_on_match))
    else $error("regulator match wrong");
  a_osc_outputs: assert property ({o_osc_mode_out, o_osc_select_out} ==
                                  $past({ctrl_q.oscillator_mode_field, ctrl_q.osc_own}))
    else $error("oscillator outputs wrong");
  a_ctrl_read: assert property (i_cfg_addr == rtcs_pkg::ADDR_CTRL_STAT && !i_cfg_wr && sup_s
                                |=> o_cfg_rdata == $past(ctrl_q) && $stable(ctrl_q))
    else $error("status read wrong");
  a_match_raw: assert property (!$past(i_rst) |-> o_match_raw == $past(eq))
    else $error("raw match wrong");

  // ==========================================================
  // Reset and release
  // Low supply holds the timekeeping state at once
  a_supply_hold: assert property (!sup_s |-> int_rst)
    else $error("reset not held under low supply");

  a_bit7_clear: assert property (ctrl_q.rtc_reset |=> cnt_q == '0 && match_q == '0)
    else $error("bit 7 left counter or match");

  a_rst_psc_zero: assert property (int_rst |=> psc_q == 7'h0)
    else $error("prescaler ran in reset");

  // Two quiet edges before any count may start
  a_release_hold: assert property ($rose(run_ok) |-> int_rst ##1 int_rst)
    else $error("reset released in under two edges");

  // ==========================================================
  // Prescaler and counter
  a_psc_disabled: assert property (!ctrl_q.cntr_en |=> psc_q == 7'h0)
    else $error("prescaler ran while disabled");

  a_psc_wrap: assert property (psc_q == 7'h7f && xtal_edge && !psc_hold
                               |=> psc_q == 7'h0)
    else $error("prescaler did not wrap");

  // Between ticks, out of reset and with count_run set, nothing but the port may move the counter
  a_hold_between: assert property (!tick && !wr_cnt && !int_rst && ctrl_q.count_run
                                   |=> $stable(cnt_q))
    else $error("counter moved between ticks");

  // Zero never self-clears, or it could not leave zero
  a_clear_skip: assert property (tick && cnt_q == '0 && !wr_cnt |=> cnt_q == 40'h1)
    else $error("counter stuck at zero");

  // Port write wins over a tick
  a_counter_write: assert property (wr_cnt && !int_rst && ctrl_q.count_run
                                    |=> byte_get(cnt_q, $past(byte_idx)) == $past(i_cfg_wdata))
    else $error("counter byte write lost");

  // ==========================================================
  // Config port
  a_ctrl_write: assert property (wr_ctrl && sup_s |=> ctrl_q == $past(i_cfg_wdata))
    else $error("control write lost");

  a_match_write: assert property (wr_match && !int_rst
                                  |=> byte_get(match_q, $past(byte_idx)) == $past(i_cfg_wdata))
    else $error("match byte write lost");

  a_match_read: assert property (rd_match
                                 |=> o_cfg_rdata ==
                                     byte_get($past(match_q), $past(byte_idx)))
    else $error("match byte read wrong");

  a_cnt_read: assert property (rd_cnt
                               |=> o_cfg_rdata == byte_get($past(cnt_q), $past(byte_idx)))
    else $error("counter byte read wrong");

  // Unmapped reads give zero so stale data never leaks
  a_unmapped_read: assert property (!rd_ctrl && !rd_cnt && !rd_match
                                    |=> o_cfg_rdata == 8'h00)
    else $error("unmapped read not zero");

  // ==========================================================
  // Main scenarios
  c_tick: cover property (tick ##1 cnt_q == 40'h1);
  c_count_write: cover property (wr_cnt && !int_rst);
  c_clear: cover property (tick && clr_hit);
  c_wake: cover property ($rose(o_regulator_match_out));
  c_release: cover property ($fell(int_rst));
endmodule
`default_nettype wire

//--- verification/rtcs_fabric_model.sv
/*
  Fabric-side model of the config port: single-cycle writes, reads.
  Assumes its tasks are called at a falling edge of the clock.
*/
`timescale 1ns/1ps
`default_nettype none
module rtcs_fabric_model
(
  input wire logic i_clock,
  input wire logic [7:0] i_rdata,
  output logic [7:0] o_addr,
  output logic [7:0] o_wdata,
  output logic o_wr
);
  // ==========================================================
  // Bus tasks
  initial
  begin
    o_addr = 8'h00;
    o_wdata = 8'h00;
    o_wr = 1'b0;
  end
  // Counter bytes are written only after enable has been cleared
  // Data inverted after the strobe so a stale byte never looks valid
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    o_addr = a;
    o_wdata = d;
    o_wr = 1'b1;
    @(negedge i_clock);
    o_wr = 1'b0;
    o_wdata = ~d;
  endtask
  // Two edges: covers a control update landing just before the read
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    o_addr = a;
    @(negedge i_clock);
    @(negedge i_clock);
    d = i_rdata;
  endtask
endmodule
`default_nettype wire

//--- verification/rtcs_control_bench.sv
/*
  Self-checking bench of the control/status block.
  Assumes a crystal far slower than the 40 MHz system clock.
*/
`timescale 1ns/1ps
`default_nettype none
module rtcs_control_bench;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic xtal = 1'b0;
  logic sup = 1'b1;
  logic [7:0] addr, wdata, rdata, rv;
  logic wr, reg_out, raw;
  logic [1:0] mode;
  logic sel;
  int num_errors = 0;
  int checks_done = 0;
  // Rows: control value, mode, select, regulator, raw match
  logic [12:0] rows [4] = '{{8'h08, 5'h09}, {8'h19, 5'h1d}, {8'h21, 5'h07}, {8'h00, 5'h01}};
  always #12.5 clk = ~clk;
  always #100 xtal = ~xtal;
  rtcs_fabric_model i_rtcs_fabric_model (.i_clock(clk), .i_rdata(rdata), .o_addr(addr),
    .o_wdata(wdata), .o_wr(wr));
  rtcs_control i_rtcs_control (.i_clock(clk), .i_rst(rst), .i_crystal_clock_in(xtal),
    .i_supply_good(sup), .i_cfg_addr(addr), .i_cfg_wdata(wdata), .i_cfg_wr(wr),
    .o_cfg_rdata(rdata), .o_regulator_match_out(reg_out), .o_match_raw(raw),
    .o_osc_mode_out(mode), .o_osc_select_out(sel));
  // ==========================================================
  // Helpers
  task automatic end_sim();
    if (num_errors == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] exp);
    i_rtcs_fabric_model.rd(a, rv);
    chk(rv, exp);
  endtask
  task automatic xe(input int n);
    repeat (n) @(posedge xtal);
    @(negedge clk);
  endtask
  task automatic wc(input logic [7:0] d);
    i_rtcs_fabric_model.wr(rtcs_pkg::ADDR_CTRL_STAT, d);
  endtask
  // ==========================================================
  // Watchdog, far beyond the ~185 us run
  initial
  begin
    #1000000;
    num_errors++;
    end_sim();
  end
  // ==========================================================
  // Tests
  initial
  begin
    repeat (3) @(negedge clk);
    rst = 1'b0;
    rc(rtcs_pkg::ADDR_CTRL_STAT, rtcs_pkg::CTRL_RESET);
    rc(8'h59, 8'h00);
    foreach (rows[i])
    begin
      wc(rows[i][12:5]);
      @(negedge clk);
      chk({3'h0, mode, sel, reg_out, raw}, {3'h0, rows[i][4:0]});
      rc(rtcs_pkg::ADDR_CTRL_STAT, rows[i][12:5]);
    end
    // Counting, pause, resume; a 4-cycle row of the walk would be too short here
    wc(8'h42);
    xe(70);
    rc(8'h40, 8'h01);
    xe(116);
    rc(8'h40, 8'h01);
    xe(12);
    rc(8'h40, 8'h02);
    wc(8'h02);
    xe(200);
    rc(8'h40, 8'h02);
    wc(8'h42);
    xe(58);
    rc(8'h40, 8'h02);
    xe(12);
    rc(8'h40, 8'h03);
    // Bit 7 clears counting state but not control
    wc(8'hc2);
    rc(8'h40, 8'h00);
    rc(rtcs_pkg::ADDR_CTRL_STAT, 8'hc2);
    wc(8'h42);
    xe(70);
    rc(8'h40, 8'h01);
    // Clear on match with the regulator path open; bit 0 keeps ownership
    i_rtcs_fabric_model.wr(rtcs_pkg::ADDR_MATCH_BASE, 8'h02);
    wc(8'h67);
    xe(124);
    chk({6'h0, raw, reg_out}, 8'h03);
    xe(128);
    rc(8'h40, 8'h00);
    xe(128);
    rc(8'h40, 8'h01);
    // Stop counting before a counter byte write
    wc(8'h27);
    i_rtcs_fabric_model.wr(8'h41, 8'h05);
    rc(8'h41, 8'h05);
    rc(rtcs_pkg::ADDR_MATCH_BASE, 8'h02);
    wc(8'h65);
    rc(8'h40, 8'h00);
    rc(8'h41, 8'h00);
    sup = 1'b0;
    repeat (4) @(negedge clk);
    rc(rtcs_pkg::ADDR_CTRL_STAT, 8'h00);
    chk({6'h0, mode, sel}, 8'h00);
    end_sim();
  end
endmodule
`default_nettype wire
